// ---- logic/twb_two_wire_bus.sv ----
// two-wire bus framing engine: master, slave, conditions, busy tracking
`include "twb_map.svh"

module twb_two_wire_bus #(
  parameter logic [15:0] HALF_CNT = 16'(`TWB_HALF_CNT)
) (
  input  wire logic                  ref_clk,                  // system clock
  input  wire logic                  reset,                    // sync, active high
  input  wire logic                  busClk,                   // link-side clock
  input  wire logic                  serial_bus_power_reduce,  // high holds block off
  input  wire logic                  cmdValid,                 // master command offered
  output logic                       cmdReady,                 // command can be taken
  input  wire twb_pkg::twb_cmd_t     cmd,                      // master command
  output logic                       rspValid,                 // one-cycle answer strobe
  output twb_pkg::twb_rsp_t          rsp,                      // answer or slave event
  input  wire twb_pkg::twb_slv_cfg_t slvCfg,                   // quasi-static slave setup
  output logic                       busBusy,                  // start seen, no stop yet
  input  wire logic                  sclIn,                    // clock line level
  input  wire logic                  sdaIn,                    // data line level
  output logic                       sclOut,                   // always low
  output logic                       sclOe,                    // pull clock line low
  output logic                       sdaOut,                   // always low
  output logic                       sdaOe                     // pull data line low
);
  import twb_pkg::*;

  typedef enum {M_IDLE, M_HOLD, M_RS, M_STA_A, M_STA_B, M_LOW, M_HIGH,
                M_STO_A, M_STO_B, M_STO_C} twb_mst_state_t;
  typedef enum {S_IDLE, S_ADDR, S_WRITE, S_READ} twb_slv_phase_t;

  function automatic twb_rsp_t mkRsp(input twb_ev_t ev, input logic [7:0] d, input logic a);
    twb_rsp_t r;
    r.ev     = ev;
    r.data   = d;
    r.ackLow = a;
    return r;
  endfunction

  function automatic logic addrHit(input logic [7:0] a, input twb_slv_cfg_t c);
    logic own;
    logic gc;
    own = (a[7:1] == c.ownAddr) && (c.ownAddr[6:3] != `TWB_RSV_TOP)
          && (c.ownAddr != `TWB_GC_ADDR);
    gc  = c.gcEnable && (a[7:1] == `TWB_GC_ADDR) && !a[0];
    return own || gc;
  endfunction

  // ------------------------------------------------------------
  // system-clock side: command and answer handshakes
  // ------------------------------------------------------------
  logic     reqTog_reg;
  logic     cmdReady_reg;
  logic     ackSeen_reg;
  logic     rspSeen_reg;
  logic     rspValid_reg;
  logic     busBusy_reg;
  twb_cmd_t cmdHold_reg;
  twb_rsp_t rsp_reg;
  logic     ackS1, ackS2, rspS1, rspS2, busyS1, busyS2;

  // link-side registers read across
  logic     ackTog_reg;
  logic     rspTog_reg;
  logic     busy_reg;
  twb_rsp_t rspLink_reg;

  always_ff @(posedge ref_clk) begin
    ackS1  <= ackTog_reg;
    ackS2  <= ackS1;
    rspS1  <= rspTog_reg;
    rspS2  <= rspS1;
    busyS1 <= busy_reg;
    busyS2 <= busyS1;
  end

  // command word stays still while a request is outstanding
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reqTog_reg   <= 1'b0;
      cmdReady_reg <= 1'b1;
      ackSeen_reg  <= 1'b0;
      cmdHold_reg  <= '0;
    end else begin
      ackSeen_reg <= ackS2;
      if (cmdValid && cmdReady_reg) begin
        cmdHold_reg  <= cmd;
        reqTog_reg   <= ~reqTog_reg;
        cmdReady_reg <= 1'b0;
      end else if (ackS2 != ackSeen_reg) begin
        cmdReady_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rspSeen_reg  <= 1'b0;
      rspValid_reg <= 1'b0;
      rsp_reg      <= '0;
      busBusy_reg  <= 1'b0;
    end else begin
      rspSeen_reg  <= rspS2;
      rspValid_reg <= (rspS2 != rspSeen_reg);
      busBusy_reg  <= busyS2;
      if (rspS2 != rspSeen_reg) begin
        rsp_reg <= rspLink_reg;
      end
    end
  end

  assign cmdReady = cmdReady_reg;
  assign rspValid = rspValid_reg;
  assign rsp      = rsp_reg;
  assign busBusy  = busBusy_reg;

  // ------------------------------------------------------------
  // link side: synchronisers and condition detection
  // ------------------------------------------------------------
  logic         rstS1, rstLink, pwrS1, pwrS2, reqS1, reqS2;
  logic         sclS1, sclS2, sdaS1, sdaS2, sclPrev, sdaPrev;
  twb_slv_cfg_t cfgS1, cfgS2;

  always_ff @(posedge busClk) begin
    rstS1   <= reset;
    rstLink <= rstS1;
    pwrS1   <= serial_bus_power_reduce;
    pwrS2   <= pwrS1;
    reqS1   <= reqTog_reg;
    reqS2   <= reqS1;
    cfgS1   <= slvCfg;
    cfgS2   <= cfgS1;
    sclS1   <= sclIn;
    sclS2   <= sclS1;
    sdaS1   <= sdaIn;
    sdaS2   <= sdaS1;
    sclPrev <= sclS2;
    sdaPrev <= sdaS2;
  end

  logic startSeen, stopSeen, sclRise, sclFall;
  assign startSeen = sclS2 && sclPrev && sdaPrev && !sdaS2;
  assign stopSeen  = sclS2 && sclPrev && !sdaPrev && sdaS2;
  assign sclRise   = sclS2 && !sclPrev;
  assign sclFall   = !sclS2 && sclPrev;

  always_ff @(posedge busClk) begin
    if (rstLink || pwrS2) begin
      busy_reg <= 1'b0;
    end else if (startSeen) begin
      busy_reg <= 1'b1;
    end else if (stopSeen) begin
      busy_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // master engine
  // ------------------------------------------------------------
  twb_mst_state_t mState_reg;
  logic [15:0]    tmr_reg;
  logic [8:0]     txVec_reg;
  logic [7:0]     rxVec_reg;
  logic [3:0]     bitCnt_reg;
  logic           mSclLow_reg, mSdaLow_reg, masterOwn_reg, nackSeen_reg;
  logic           reqSeen_reg, mDone_reg, lastWasAddr_reg, isRead_reg;
  twb_rsp_t       mRsp_reg;
  logic           newReq, take, half;

  assign newReq = (reqS2 != reqSeen_reg);
  assign take   = newReq && (mState_reg == M_IDLE || mState_reg == M_HOLD);
  assign half   = (tmr_reg == HALF_CNT - 16'd1);

  // the M_STA_A, M_HIGH and M_STO_B high phases only count while the line really is high: a slave may stretch
  always_ff @(posedge busClk) begin
    if (rstLink) begin
      mState_reg      <= M_IDLE;
      tmr_reg         <= '0;
      txVec_reg       <= '0;
      rxVec_reg       <= '0;
      bitCnt_reg      <= '0;
      mSclLow_reg     <= 1'b0;
      mSdaLow_reg     <= 1'b0;
      masterOwn_reg   <= 1'b0;
      nackSeen_reg    <= 1'b0;
      reqSeen_reg     <= 1'b0;
      mDone_reg       <= 1'b0;
      lastWasAddr_reg <= 1'b0;
      isRead_reg      <= 1'b0;
      mRsp_reg        <= '0;
    end else if (pwrS2) begin
      mState_reg    <= M_IDLE;
      mSclLow_reg   <= 1'b0;
      mSdaLow_reg   <= 1'b0;
      masterOwn_reg <= 1'b0;
      nackSeen_reg  <= 1'b0;
      mDone_reg     <= newReq;
      reqSeen_reg   <= reqS2;
      mRsp_reg      <= mkRsp(TWB_EV_REFUSED, 8'h00, 1'b0);
    end else begin
      mDone_reg <= 1'b0;
      tmr_reg   <= half ? 16'd0 : tmr_reg + 16'd1;
      unique case (mState_reg)
        M_IDLE, M_HOLD: begin
          tmr_reg <= '0;
          if (take) begin
            reqSeen_reg <= reqS2;
            mDone_reg   <= 1'b1;
            mRsp_reg    <= mkRsp(TWB_EV_REFUSED, 8'h00, 1'b0);
            unique case (cmdHold_reg.op)
              TWB_OP_START: begin
                if (mState_reg == M_HOLD) begin
                  mState_reg <= M_RS;
                  mDone_reg  <= 1'b0;
                end else if (!busy_reg) begin
                  mState_reg <= M_STA_A;
                  mDone_reg  <= 1'b0;
                end
              end
              TWB_OP_WRITE, TWB_OP_READ: begin
                if (mState_reg == M_HOLD && !nackSeen_reg) begin
                  isRead_reg <= (cmdHold_reg.op == TWB_OP_READ);
                  txVec_reg  <= (cmdHold_reg.op == TWB_OP_READ) ?
                                {8'hff, cmdHold_reg.nack} :
                                {cmdHold_reg.data, 1'b1};
                  bitCnt_reg <= '0;
                  mState_reg <= M_LOW;
                  mDone_reg  <= 1'b0;
                end
              end
              TWB_OP_STOP: begin
                if (mState_reg == M_HOLD) begin
                  mState_reg <= M_STO_A;
                  mDone_reg  <= 1'b0;
                end
              end
            endcase
          end
        end
        M_RS: begin
          mSdaLow_reg <= 1'b0;
          if (half) begin
            mState_reg <= M_STA_A;
          end
        end
        M_STA_A: begin
          mSclLow_reg <= 1'b0;
          if (!sclS2) begin
            tmr_reg <= '0;
          end else if (half) begin
            mSdaLow_reg <= 1'b1;
            mState_reg  <= M_STA_B;
          end
        end
        M_STA_B: begin
          if (half) begin
            mSclLow_reg     <= 1'b1;
            masterOwn_reg   <= 1'b1;
            nackSeen_reg    <= 1'b0;
            lastWasAddr_reg <= 1'b1;
            mState_reg      <= M_HOLD;
            mDone_reg       <= 1'b1;
            mRsp_reg        <= mkRsp(TWB_EV_DONE, 8'h00, 1'b0);
          end
        end
        M_LOW: begin
          mSdaLow_reg <= !txVec_reg[8];
          if (half) begin
            mSclLow_reg <= 1'b0;
            mState_reg  <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (!sclS2) begin
            tmr_reg <= '0;
          end else if (half) begin
            mSclLow_reg <= 1'b1;
            txVec_reg   <= {txVec_reg[7:0], 1'b1};
            rxVec_reg   <= {rxVec_reg[6:0], sdaS2};
            bitCnt_reg  <= bitCnt_reg + 4'h1;
            mState_reg  <= M_LOW;
            if (bitCnt_reg == `TWB_ACK_BIT) begin
              mState_reg      <= M_HOLD;
              mDone_reg       <= 1'b1;
              mRsp_reg        <= mkRsp(TWB_EV_DONE, rxVec_reg, !sdaS2);
              nackSeen_reg    <= sdaS2 && lastWasAddr_reg && !isRead_reg;
              lastWasAddr_reg <= 1'b0;
            end
          end
        end
        M_STO_A: begin
          mSdaLow_reg <= 1'b1;
          if (half) begin
            mSclLow_reg <= 1'b0;
            mState_reg  <= M_STO_B;
          end
        end
        M_STO_B: begin
          if (!sclS2) begin
            tmr_reg <= '0;
          end else if (half) begin
            mSdaLow_reg <= 1'b0;
            mState_reg  <= M_STO_C;
          end
        end
        M_STO_C: begin
          if (half) begin
            masterOwn_reg <= 1'b0;
            nackSeen_reg  <= 1'b0;
            mState_reg    <= M_IDLE;
            mDone_reg     <= 1'b1;
            mRsp_reg      <= mkRsp(TWB_EV_DONE, 8'h00, 1'b0);
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // slave engine
  // ------------------------------------------------------------
  twb_slv_phase_t sPhase_reg;
  logic [3:0]     sCnt_reg;
  logic [7:0]     sShift_reg, sTx_reg;
  logic           sSdaLow_reg, sMasterAck_reg, sEv_reg;
  twb_rsp_t       sRsp_reg;

  // the first clock fall after a start precedes bit zero, hence the pre-bit count
  always_ff @(posedge busClk) begin
    if (rstLink || pwrS2 || masterOwn_reg || stopSeen) begin
      sPhase_reg     <= S_IDLE;
      sCnt_reg       <= `TWB_PRE_BIT;
      sShift_reg     <= '0;
      sTx_reg        <= '0;
      sSdaLow_reg    <= 1'b0;
      sMasterAck_reg <= 1'b0;
      sEv_reg        <= 1'b0;
      sRsp_reg       <= '0;
    end else if (startSeen) begin
      sPhase_reg  <= S_ADDR;
      sCnt_reg    <= `TWB_PRE_BIT;
      sSdaLow_reg <= 1'b0;
      sEv_reg     <= 1'b0;
    end else begin
      sEv_reg <= 1'b0;
      if (sPhase_reg != S_IDLE && sclRise) begin
        if (sCnt_reg != `TWB_ACK_BIT) begin
          sShift_reg <= {sShift_reg[6:0], sdaS2};
        end else begin
          sMasterAck_reg <= !sdaS2;
        end
      end
      if (sPhase_reg != S_IDLE && sclFall) begin
        if (sCnt_reg == `TWB_LAST_BIT) begin
          sCnt_reg <= `TWB_ACK_BIT;
          unique case (sPhase_reg)
            S_ADDR: begin
              if (addrHit(sShift_reg, cfgS2) && cfgS2.ackEnable) begin
                sSdaLow_reg <= 1'b1;
                sEv_reg     <= 1'b1;
                sRsp_reg    <= mkRsp(TWB_EV_SLV_ADDR, sShift_reg, 1'b1);
              end else begin
                sPhase_reg  <= S_IDLE;
              end
            end
            S_WRITE: begin
              sSdaLow_reg <= cfgS2.ackEnable;
              sEv_reg     <= 1'b1;
              sRsp_reg    <= mkRsp(TWB_EV_SLV_DATA, sShift_reg, cfgS2.ackEnable);
            end
            S_READ: begin
              sSdaLow_reg <= 1'b0;
            end
            default: begin
              sSdaLow_reg <= 1'b0;
            end
          endcase
        end else if (sCnt_reg == `TWB_ACK_BIT) begin
          sCnt_reg    <= '0;
          sSdaLow_reg <= 1'b0;
          if ((sPhase_reg == S_ADDR && sShift_reg[0]) ||
              (sPhase_reg == S_READ && sMasterAck_reg)) begin
            sPhase_reg  <= S_READ;
            sTx_reg     <= cfgS2.txByte;
            sSdaLow_reg <= !cfgS2.txByte[7];
          end else if (sPhase_reg == S_READ) begin
            sPhase_reg  <= S_IDLE;
          end else begin
            sPhase_reg  <= S_WRITE;
          end
        end else begin
          sCnt_reg <= sCnt_reg + 4'h1;
          if (sPhase_reg == S_READ) begin
            sTx_reg     <= {sTx_reg[6:0], 1'b1};
            sSdaLow_reg <= !sTx_reg[6];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // answers back to the system side, and pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge busClk) begin
    if (rstLink) begin
      ackTog_reg  <= 1'b0;
      rspTog_reg  <= 1'b0;
      rspLink_reg <= '0;
    end else if (mDone_reg) begin
      ackTog_reg  <= ~ackTog_reg;
      rspTog_reg  <= ~rspTog_reg;
      rspLink_reg <= mRsp_reg;
    end else if (sEv_reg) begin
      rspTog_reg  <= ~rspTog_reg;
      rspLink_reg <= sRsp_reg;
    end
  end

  logic sclOe_reg, sdaOe_reg, sclOut_reg, sdaOut_reg;

  // outputs are enables only; the driven level is fixed low
  always_ff @(posedge busClk) begin
    if (rstLink) begin
      sclOe_reg  <= 1'b0;
      sdaOe_reg  <= 1'b0;
      sclOut_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end else begin
      sclOe_reg  <= mSclLow_reg && !pwrS2;
      sdaOe_reg  <= (mSdaLow_reg || sSdaLow_reg) && !pwrS2;
      sclOut_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end
  end

  assign sclOe  = sclOe_reg;
  assign sdaOe  = sdaOe_reg;
  assign sclOut = sclOut_reg;
  assign sdaOut = sdaOut_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cbLink @(posedge busClk); endclocking
  default disable iff (rstLink);

  sequence seqStartEdge;
    mState_reg == M_STA_A && sclS2 && half;
  endsequence
  sequence seqStartHeld;
    mSdaLow_reg && !mSclLow_reg ##1 sdaOe_reg && !sclOe_reg;
  endsequence

  chk_sda_stable: assert property ((mState_reg == M_HIGH && $past(mState_reg) == M_HIGH)
    |-> $stable(mSdaLow_reg)) else $error("data moved while clock high");
  chk_start_shape: assert property (seqStartEdge |=> seqStartHeld)
    else $error("start not made with clock high");
  chk_busy_start: assert property (startSeen && !pwrS2 |=> busy_reg)
    else $error("busy not set by start");
  chk_busy_stop: assert property (stopSeen && !startSeen |=> !busy_reg)
    else $error("busy not cleared by stop");
  chk_refuse_busy: assert property ((take && mState_reg == M_IDLE && busy_reg && !pwrS2
    && cmdHold_reg.op == TWB_OP_START) |=> mState_reg == M_IDLE && mDone_reg
    && mRsp_reg.ev == TWB_EV_REFUSED) else $error("start taken on busy bus");
  chk_nine_bits: assert property ((mState_reg == M_HIGH && sclS2 && half && !pwrS2
    && bitCnt_reg == `TWB_ACK_BIT) |=> mState_reg == M_HOLD && mDone_reg)
    else $error("packet not nine bits");
  chk_msb_first: assert property ((take && mState_reg == M_HOLD && !nackSeen_reg && !pwrS2
    && cmdHold_reg.op == TWB_OP_WRITE) |=> txVec_reg[8] == $past(cmdHold_reg.data[7]))
    else $error("first bit is not the top bit");
  chk_nack_follow: assert property ((take && nackSeen_reg && !pwrS2
    && cmdHold_reg.op == TWB_OP_WRITE) |=> mRsp_reg.ev == TWB_EV_REFUSED)
    else $error("data accepted after address refused");
  chk_slave_ack: assert property ((sclFall && sPhase_reg == S_WRITE && !startSeen && !stopSeen
    && !pwrS2 && !masterOwn_reg && sCnt_reg == `TWB_LAST_BIT && cfgS2.ackEnable)
    |=> sSdaLow_reg ##1 sdaOe_reg) else $error("slave failed to acknowledge");
  chk_open_drain: assert property (!sclOut_reg && !sdaOut_reg)
    else $error("line driven high");
  chk_power_off: assert property (pwrS2 [*2] |-> !sclOe_reg && !sdaOe_reg)
    else $error("lines pulled while powered down");

endmodule

// ---- pkg/twb_map.svh ----
// constants of the two-wire bus framing block
`ifndef TWB_MAP_SVH
`define TWB_MAP_SVH

// ------------------------------------------------------------
// address space
// ------------------------------------------------------------
`define TWB_GC_ADDR    7'h00
`define TWB_RSV_TOP    4'hf

// ------------------------------------------------------------
// packet bit positions
// ------------------------------------------------------------
`define TWB_PRE_BIT    4'hf
`define TWB_LAST_BIT   4'h7
`define TWB_ACK_BIT    4'h8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TWB_T_HALF_NS  1250
`define TWB_LINK_PS    6000
`define TWB_HALF_CNT   ((`TWB_T_HALF_NS * 1000 + `TWB_LINK_PS - 1) / `TWB_LINK_PS)

`endif

// ---- pkg/twb_pkg.sv ----
// types shared by the two-wire bus framing block
package twb_pkg;

  typedef enum logic [1:0] {
    TWB_OP_START,
    TWB_OP_WRITE,
    TWB_OP_READ,
    TWB_OP_STOP
  } twb_op_t;

  typedef struct packed {
    twb_op_t    op;
    logic [7:0] data;
    logic       nack;
  } twb_cmd_t;

  typedef enum logic [2:0] {
    TWB_EV_DONE,
    TWB_EV_REFUSED,
    TWB_EV_SLV_ADDR,
    TWB_EV_SLV_DATA
  } twb_ev_t;

  typedef struct packed {
    twb_ev_t    ev;
    logic [7:0] data;
    logic       ackLow;
  } twb_rsp_t;

  typedef struct packed {
    logic [6:0] ownAddr;
    logic       gcEnable;
    logic       ackEnable;
    logic [7:0] txByte;
  } twb_slv_cfg_t;

endpackage

// ---- dv/twb_bus_partner.sv ----
// behavioural slave on the shared bus, the far side of the framing block
module twb_bus_partner #(
  parameter logic [6:0] ADDR = 7'h52
) (
  input  wire logic scl,      // resolved clock line
  input  wire logic sda,      // resolved data line
  output logic      sdaPull   // high pulls data line low
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bitCnt = -1;
  logic [7:0] shReg  = 8'h00;
  logic       sel    = 1'b0;
  logic       first  = 1'b0;
  logic       rd     = 1'b0;
  initial sdaPull = 1'b0;
  always @(negedge sda) if (scl === 1'b1) begin bitCnt = 0; first = 1'b1; sel = 1'b0; end
  always @(posedge sda) if (scl === 1'b1) begin bitCnt = -1; sdaPull = 1'b0; end
  always @(posedge scl) if (bitCnt >= 0 && bitCnt < 8) begin shReg = {shReg[6:0], sda}; bitCnt++; end
  // reads answer with a released line, so the master sees all ones
  always @(negedge scl) begin
    if (bitCnt == 8) begin
      if (first) begin sel = (shReg[7:1] == ADDR); rd = shReg[0]; end
      #20 sdaPull = sel && (first || !rd);
      bitCnt = 9;
    end else if (bitCnt == 9) begin
      #20 sdaPull = 1'b0;
      bitCnt = 0;
      first  = 1'b0;
    end
  end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench of the two-wire bus framing block
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import twb_pkg::*;
  typedef struct packed {twb_cmd_t c; twb_ev_t ev; logic [7:0] d; logic a;} twb_row_t;
  logic         ref_clk = 0, busClk = 0, reset = 1, pwrOff = 0, cmdValid = 0;
  logic         cmdReady, rspValid, busBusy, sclOut, sclOe, sdaOut, sdaOe, pSda;
  logic         bScl = 0, bSda = 0, ack = 0, bsy = 0;
  logic [7:0]   rx = 8'h00;
  twb_cmd_t     cmd = '0;
  twb_rsp_t     rsp, lastRsp = '0;
  twb_slv_cfg_t cfg = '{7'h33, 1'b1, 1'b1, 8'h69};
  int           err_total = 0, comparisons = 0, rspCnt = 0;
  wire logic    sclLine = !(sclOe | bScl);
  wire logic    sdaLine = !(sdaOe | pSda | bSda);
  twb_row_t rows [13] = '{
    '{'{TWB_OP_STOP, 8'h00, 1'b0}, TWB_EV_REFUSED, 8'h00, 1'b0},
    '{'{TWB_OP_START, 8'h00, 1'b0}, TWB_EV_DONE, 8'h00, 1'b0},
    '{'{TWB_OP_WRITE, 8'ha4, 1'b0}, TWB_EV_DONE, 8'ha4, 1'b1},
    '{'{TWB_OP_WRITE, 8'h3c, 1'b0}, TWB_EV_DONE, 8'h3c, 1'b1},
    '{'{TWB_OP_START, 8'h00, 1'b0}, TWB_EV_DONE, 8'h00, 1'b0},
    '{'{TWB_OP_WRITE, 8'ha5, 1'b0}, TWB_EV_DONE, 8'ha5, 1'b1},
    '{'{TWB_OP_READ, 8'h00, 1'b0}, TWB_EV_DONE, 8'hff, 1'b1},
    '{'{TWB_OP_READ, 8'h00, 1'b1}, TWB_EV_DONE, 8'hff, 1'b0},
    '{'{TWB_OP_START, 8'h00, 1'b0}, TWB_EV_DONE, 8'h00, 1'b0},
    '{'{TWB_OP_WRITE, 8'h20, 1'b0}, TWB_EV_DONE, 8'h20, 1'b0},
    '{'{TWB_OP_WRITE, 8'h11, 1'b0}, TWB_EV_REFUSED, 8'h00, 1'b0},
    '{'{TWB_OP_STOP, 8'h00, 1'b0}, TWB_EV_DONE, 8'h00, 1'b0},
    '{'{TWB_OP_READ, 8'h00, 1'b0}, TWB_EV_REFUSED, 8'h00, 1'b0}};
  always #25 ref_clk = ~ref_clk;
  initial begin #1.7; forever #3 busClk = ~busClk; end
  always @(posedge ref_clk) if (rspValid === 1'b1) begin lastRsp <= rsp; rspCnt <= rspCnt + 1; end
  twb_two_wire_bus #(.HALF_CNT(16'h0008)) twb_two_wire_bus_inst (
    .ref_clk(ref_clk), .reset(reset), .busClk(busClk), .serial_bus_power_reduce(pwrOff),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .rspValid(rspValid), .rsp(rsp),
    .slvCfg(cfg), .busBusy(busBusy), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
  twb_bus_partner twb_bus_partner_inst (.scl(sclLine), .sda(sdaLine), .sdaPull(pSda));
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task go(input twb_cmd_t c);
    int n, i;
    n = rspCnt;
    @(posedge ref_clk) #2 cmdValid = 1'b1;
    cmd = c;
    for (i = 0; i < 100 && cmdReady !== 1'b1; i++) @(posedge ref_clk) #2;
    @(posedge ref_clk) #2 cmdValid = 1'b0;
    for (i = 0; i < 2000 && rspCnt == n; i++) @(posedge ref_clk) #2;
    if (rspCnt == n) err_total++;
  endtask
  // bench stands in for a foreign master; steps of three clocks keep inputs off the edge
  task ln(input logic c, input logic d);
    #150 bScl = !c;
    bSda = !d;
  endtask
  task bbByte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin ln(0, b[k]); ln(1, b[k]); rx[k] = sdaLine; ln(0, b[k]); end
    ln(0, 1); ln(1, 1); ack = sdaLine; ln(0, 1); #400;
  endtask
  task bbStart(); ln(1, 1); ln(1, 0); ln(0, 0); endtask
  task bbStop(); ln(0, 0); ln(1, 0); ln(1, 1); endtask
  task print_verdict();
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin #3000000; err_total++; print_verdict(); end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    #2 reset = 1'b0;
    repeat (12) @(posedge ref_clk) #2;
    `CHK("ready", 1'b1, cmdReady)
    `CHK("busy", 1'b0, busBusy)
    `CHK("pins", 2'b00, {sclOe, sdaOe})
    for (int r = 0; r < 13; r++) begin
      go(rows[r].c);
      `CHK("ev", rows[r].ev, lastRsp.ev)
      if (rows[r].ev == TWB_EV_DONE && rows[r].c.op inside {TWB_OP_WRITE, TWB_OP_READ}) begin
        `CHK("data", rows[r].d, lastRsp.data)
        `CHK("ack", rows[r].a, lastRsp.ackLow)
      end
      if (rows[r].ev == TWB_EV_DONE && rows[r].c.op == TWB_OP_START) bsy = 1'b1;
      if (rows[r].ev == TWB_EV_DONE && rows[r].c.op == TWB_OP_STOP) bsy = 1'b0;
      repeat (8) @(posedge ref_clk) #2;
      `CHK("busy", bsy, busBusy)
    end
    pwrOff = 1'b1;
    repeat (20) @(posedge ref_clk) #2;
    go('{TWB_OP_START, 8'h00, 1'b0});
    `CHK("off", TWB_EV_REFUSED, lastRsp.ev)
    pwrOff = 1'b0;
    repeat (20) @(posedge ref_clk) #2;
    bbStart();
    go('{TWB_OP_START, 8'h00, 1'b0});
    `CHK("busy start", TWB_EV_REFUSED, lastRsp.ev)
    bbByte(8'h66);
    `CHK("own ack", 1'b0, ack)
    `CHK("slv addr", {TWB_EV_SLV_ADDR, 8'h66}, {lastRsp.ev, lastRsp.data})
    bbByte(8'h5a);
    `CHK("data ack", 1'b0, ack)
    `CHK("slv data", {TWB_EV_SLV_DATA, 8'h5a}, {lastRsp.ev, lastRsp.data})
    bbStart(); bbByte(8'h00);
    `CHK("gc ack", 1'b0, ack)
    bbStart(); bbByte(8'h01);
    `CHK("gc rd", 1'b1, ack)
    bbStart(); bbByte(8'h67);
    `CHK("rd ack", 1'b0, ack)
    `CHK("slv rd", {TWB_EV_SLV_ADDR, 8'h67}, {lastRsp.ev, lastRsp.data})
    bbByte(8'hff);
    `CHK("slv tx", 8'h69, rx)
    `CHK("slv end", 1'b0, sdaOe)
    bbStop();
    cfg.ownAddr = 7'h78;
    repeat (10) @(posedge ref_clk) #2;
    bbStart(); bbByte(8'hf0);
    `CHK("rsv", 1'b1, ack)
    bbStop();
    repeat (10) @(posedge ref_clk) #2;
    go('{TWB_OP_START, 8'h00, 1'b0});
    `CHK("restart", TWB_EV_DONE, lastRsp.ev)
    reset = 1'b1;
    repeat (3) @(posedge ref_clk) #2;
    reset = 1'b0;
    repeat (12) @(posedge ref_clk) #2;
    `CHK("rst", 5'b10000, {cmdReady, rspValid, busBusy, sclOe, sdaOe})
    `CHK("idle", 3'b000, {busBusy, sclOut, sdaOut})
    print_verdict();
  end
endmodule
